// [rtl/acm_ctrl.sv]
// How it works
// - A control bit changes only when its gate bit (position plus 8) is set.
// - Control registers take only full 16-bit writes; narrower ones are refused.
// - Registers sit at 0x5C, 0x5E and gain at 0x62 behind bases 0x200 and 0x300.
// - Control 1 bit 7 enables temperature compensation, resets to 1.
// - Control 1 bit 6 enables voltage compensation, resets to 1.
// - Control 1 bit 5 enables current compensation, resets to 1.
// - Control 1 bit 4 enables the current/voltage low-pass filter, resets to 0.
// - Control 1 bits 3..1 enable choppers ext temp, int temp, voltage; reset 0.
// - Control 1 bit 0 selects automatic gain, else manual gain; resets to 1.
// - Manual gain writes apply only without auto gain; reads show gain in use.
// - Control 0 bit 7 shorts current and voltage converter inputs, resets 0.
// - Control 0 bit 6 enables supply pin capacitor compensation, resets 0.
// - Control 0 bits 5..3 select standard converter gain when 1; reset 1.
// - Control 0 bits 2..0 add about 100 ns converter input delay; reset 0.
`timescale 1ns/10ps
`include "acm_defs.svh"

module acm_ctrl (
   input wire logic clk_i,
   input wire logic resetn_i,
   // register bus
   input wire logic [`ACM_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [`ACM_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // gain from the automatic gain controller
   input wire logic [`ACM_GAIN_W-1:0] auto_gain_code_i,
   // chain control 1
   output logic temp_channel_comp_on_o,
   output logic volt_channel_comp_on_o,
   output logic curr_channel_comp_on_o,
   output logic lowpass_filter_on_o,
   output logic ext_temp_chopper_on_o,
   output logic int_temp_chopper_on_o,
   output logic volt_chopper_on_o,
   output logic auto_gain_on_o,
   // chain control 0
   output logic input_short_on_o,
   output logic supply_pin_cap_comp_o,
   output logic temp_converter_gain_sel_o,
   output logic volt_converter_gain_sel_o,
   output logic curr_converter_gain_sel_o,
   output logic temp_input_delay_on_o,
   output logic volt_input_delay_on_o,
   output logic curr_input_delay_on_o,
   // amplifier gain in use
   output logic [`ACM_GAIN_W-1:0] amplifier_gain_field_o
);
   import acm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // write channel state

   logic aw_held;
   logic [`ACM_ADDR_W-1:0] aw_addr;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic bvalid;
   logic [1:0] bresp;
   logic next_aw_held;
   logic [`ACM_ADDR_W-1:0] next_aw_addr;
   logic next_w_held;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_bvalid;
   logic [1:0] next_bresp;

   logic wr_fire;
   acm_sel_t wr_sel;
   logic full16;
   logic wr_ctrl1;
   logic wr_ctrl0;
   logic wr_gain;
   logic [`ACM_CTRL_W-1:0] wr_val;
   logic [`ACM_CTRL_W-1:0] wr_gate;
   logic [`ACM_CTRL_W-1:0] ctrl1;
   logic [`ACM_CTRL_W-1:0] ctrl0;

   // address and data are taken independently, one write at a time
   assign s_axi_awready_o = !aw_held;
   assign s_axi_wready_o = !w_held;
   assign s_axi_bvalid_o = bvalid;
   assign s_axi_bresp_o = bresp;

   // write decode once both halves are held
   assign wr_fire = aw_held && w_held && !bvalid;
   assign wr_sel = acm_decode(aw_addr);
   assign full16 = &w_strb[1:0];
   assign wr_ctrl1 = wr_fire && (wr_sel == ACM_SEL_CTRL1) && full16;
   assign wr_ctrl0 = wr_fire && (wr_sel == ACM_SEL_CTRL0) && full16;
   assign wr_gain = wr_fire && (wr_sel == ACM_SEL_GAIN) && w_strb[0];
   assign wr_val = w_data[`ACM_VAL_MSB:0];
   assign wr_gate = w_data[`ACM_GATE_MSB:`ACM_GATE_LSB];

   // write channel next state
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (s_axi_awvalid_i && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata_i;
         next_w_strb = s_axi_wstrb_i;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = (wr_ctrl1 || wr_ctrl0 || wr_gain) ? `ACM_RESP_OKAY
                                                        : `ACM_RESP_SLVERR;
      end else if (bvalid && s_axi_bready_i) begin
         next_bvalid = 1'b0;
      end
   end

   // write channel registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= `ACM_RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers

   // chain control 1, compensation, filter, chopper and gain mode
   acm_masked_reg #(
      .RESET_VAL(`ACM_CTRL1_RESET)
   ) u_ctrl1 (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_i(wr_ctrl1),
      .wdata_i(wr_val),
      .wmask_i(wr_gate),
      .value_o(ctrl1)
   );

   // chain control 0, input short, capacitor, converter gain and delay
   acm_masked_reg #(
      .RESET_VAL(`ACM_CTRL0_RESET)
   ) u_ctrl0 (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_i(wr_ctrl0),
      .wdata_i(wr_val),
      .wmask_i(wr_gate),
      .value_o(ctrl0)
   );

   // chain control 1 fields
   assign temp_channel_comp_on_o = ctrl1[`ACM_C1_TEMP_COMP];
   assign volt_channel_comp_on_o = ctrl1[`ACM_C1_VOLT_COMP];
   assign curr_channel_comp_on_o = ctrl1[`ACM_C1_CURR_COMP];
   assign lowpass_filter_on_o = ctrl1[`ACM_C1_LOWPASS];
   assign ext_temp_chopper_on_o = ctrl1[`ACM_C1_EXT_CHOP];
   assign int_temp_chopper_on_o = ctrl1[`ACM_C1_INT_CHOP];
   assign volt_chopper_on_o = ctrl1[`ACM_C1_VOLT_CHOP];
   assign auto_gain_on_o = ctrl1[`ACM_C1_AUTO_GAIN];

   // chain control 0 fields
   assign input_short_on_o = ctrl0[`ACM_C0_SHORT];
   assign supply_pin_cap_comp_o = ctrl0[`ACM_C0_CAP_COMP];
   assign temp_converter_gain_sel_o = ctrl0[`ACM_C0_TEMP_GSEL];
   assign volt_converter_gain_sel_o = ctrl0[`ACM_C0_VOLT_GSEL];
   assign curr_converter_gain_sel_o = ctrl0[`ACM_C0_CURR_GSEL];
   assign temp_input_delay_on_o = ctrl0[`ACM_C0_TEMP_DLY];
   assign volt_input_delay_on_o = ctrl0[`ACM_C0_VOLT_DLY];
   assign curr_input_delay_on_o = ctrl0[`ACM_C0_CURR_DLY];

   // amplifier gain, auto or manual
   acm_gain_sel u_gain (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .auto_i(auto_gain_on_o),
      .auto_code_i(auto_gain_code_i),
      .wr_i(wr_gain),
      .wcode_i(w_data[`ACM_GAIN_W-1:0]),
      .gain_o(amplifier_gain_field_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // read channel

   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   acm_sel_t rd_sel;

   assign s_axi_arready_o = !rvalid;
   assign s_axi_rvalid_o = rvalid;
   assign s_axi_rdata_o = rdata;
   assign s_axi_rresp_o = rresp;
   assign rd_sel = acm_decode(s_axi_araddr_i);

   // read mux, gate bits always read zero
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (s_axi_arvalid_i && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = `ACM_RESP_OKAY;
         case (rd_sel)
            ACM_SEL_CTRL1: begin
               next_rdata = {24'h000000, ctrl1};
            end
            ACM_SEL_CTRL0: begin
               next_rdata = {24'h000000, ctrl0};
            end
            ACM_SEL_GAIN: begin
               next_rdata = {29'h00000000, amplifier_gain_field_o};
            end
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = `ACM_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && s_axi_rready_i) begin
         next_rvalid = 1'b0;
      end
   end

   // read channel registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `ACM_RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // ungated bit holds across a write
   temp_gate_hold_a: assert property (
      wr_ctrl1 && !wr_gate[`ACM_C1_TEMP_COMP] |=> $stable(temp_channel_comp_on_o))
      else $error("ungated temperature compensation bit changed");

   // low-pass enable follows gate 12
   lowpass_gate_a: assert property (
      wr_ctrl1 && wr_gate[`ACM_C1_LOWPASS] |=> lowpass_filter_on_o == $past(wr_val[4]))
      else $error("gated low-pass write not applied");

   // chain control 0 masked update
   ctrl0_update_a: assert property (
      wr_ctrl0 |=> ctrl0 == (($past(ctrl0) & ~$past(wr_gate)) | ($past(wr_val) & $past(wr_gate))))
      else $error("chain control 0 masked update wrong");

   // read of a control register shows no gate bits
   upper_zero_a: assert property (
      s_axi_arvalid_i && !rvalid && (rd_sel == ACM_SEL_CTRL1 || rd_sel == ACM_SEL_CTRL0)
      |=> rvalid && rdata[31:8] == 24'h000000 && rresp == `ACM_RESP_OKAY)
      else $error("control read shows upper bits");

   // narrow write to a control register refused
   narrow_reject_a: assert property (
      wr_fire && (wr_sel == ACM_SEL_CTRL1 || wr_sel == ACM_SEL_CTRL0) && !full16
      |=> bvalid && bresp == `ACM_RESP_SLVERR && $stable(ctrl1) && $stable(ctrl0))
      else $error("narrow control write not refused");

   // unmapped read answers with an error
   unmapped_read_a: assert property (
      s_axi_arvalid_i && !rvalid && rd_sel == ACM_SEL_NONE
      |=> rvalid && rresp == `ACM_RESP_SLVERR)
      else $error("unmapped read not refused");

   // auto gain tracks the controller
   auto_gain_a: assert property (
      resetn_i && auto_gain_on_o |=> amplifier_gain_field_o == $past(auto_gain_code_i))
      else $error("auto gain not followed");

   // manual gain holds without a write
   manual_gain_a: assert property (
      !auto_gain_on_o && !wr_gain |=> $stable(amplifier_gain_field_o))
      else $error("manual gain changed without a write");

   // write response waits for ready
   bresp_hold_a: assert property (
      bvalid && !s_axi_bready_i |=> bvalid && $stable(bresp))
      else $error("write response dropped early");

endmodule : acm_ctrl

// [rtl/acm_defs.svh]
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

// register indices inside the acquisition window (word units)
`define ACM_IDX_CTRL1 10'h05c
`define ACM_IDX_CTRL0 10'h05e
`define ACM_IDX_GAIN 10'h062

// window bases: blocking and non-blocking views of the same registers
`define ACM_BASE_BLOCKING 10'h200
`define ACM_BASE_NONBLOCKING 10'h300

// byte address = 4 * (base + index)
`define ACM_ADDR_W 12
`define ACM_WORD_LSB 2

// control fields: low byte holds values, high byte holds write gates
`define ACM_CTRL_W 8
`define ACM_GATE_LSB 8
`define ACM_GATE_MSB 15
`define ACM_VAL_MSB 7

// reset values of the control bytes
`define ACM_CTRL1_RESET 8'he1
`define ACM_CTRL0_RESET 8'h38

// amplifier gain field
`define ACM_GAIN_W 3
`define ACM_GAIN_RESET 3'h0

// bit positions of chain control 1
`define ACM_C1_TEMP_COMP 7
`define ACM_C1_VOLT_COMP 6
`define ACM_C1_CURR_COMP 5
`define ACM_C1_LOWPASS 4
`define ACM_C1_EXT_CHOP 3
`define ACM_C1_INT_CHOP 2
`define ACM_C1_VOLT_CHOP 1
`define ACM_C1_AUTO_GAIN 0

// bit positions of chain control 0
`define ACM_C0_SHORT 7
`define ACM_C0_CAP_COMP 6
`define ACM_C0_TEMP_GSEL 5
`define ACM_C0_VOLT_GSEL 4
`define ACM_C0_CURR_GSEL 3
`define ACM_C0_TEMP_DLY 2
`define ACM_C0_VOLT_DLY 1
`define ACM_C0_CURR_DLY 0

// bus responses
`define ACM_RESP_OKAY 2'b00
`define ACM_RESP_SLVERR 2'b10

// converter input delay, applied in the analog chain
`define ACM_CLK_NS 25
`define ACM_INPUT_DELAY_NS 100
`define ACM_INPUT_DELAY_CYC ((`ACM_INPUT_DELAY_NS + `ACM_CLK_NS - 1) / `ACM_CLK_NS)

`endif

// [rtl/acm_gain_sel.sv]
`timescale 1ns/10ps
`include "acm_defs.svh"

module acm_gain_sel (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic auto_i,
   input wire logic [`ACM_GAIN_W-1:0] auto_code_i,
   input wire logic wr_i,
   input wire logic [`ACM_GAIN_W-1:0] wcode_i,
   output logic [`ACM_GAIN_W-1:0] gain_o
);
   import acm_pkg::*;

   logic [`ACM_GAIN_W-1:0] next_gain;

   // auto mode tracks the gain controller, manual mode takes writes
   always_comb begin
      next_gain = gain_o;
      if (auto_i) begin
         next_gain = auto_code_i;
      end else if (wr_i) begin
         next_gain = wcode_i;
      end
   end

   // gain in use
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gain_o <= `ACM_GAIN_RESET;
      end else begin
         gain_o <= next_gain;
      end
   end

endmodule : acm_gain_sel

// [rtl/acm_masked_reg.sv]
`timescale 1ns/10ps
`include "acm_defs.svh"

module acm_masked_reg #(
   parameter logic [`ACM_CTRL_W-1:0] RESET_VAL = 8'h00
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wr_i,
   input wire logic [`ACM_CTRL_W-1:0] wdata_i,
   input wire logic [`ACM_CTRL_W-1:0] wmask_i,
   output logic [`ACM_CTRL_W-1:0] value_o
);
   import acm_pkg::*;

   logic [`ACM_CTRL_W-1:0] next_value;

   // only gated bits take the written value
   always_comb begin
      next_value = value_o;
      if (wr_i) begin
         next_value = (value_o & ~wmask_i) | (wdata_i & wmask_i);
      end
   end

   // control byte storage
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         value_o <= RESET_VAL;
      end else begin
         value_o <= next_value;
      end
   end

endmodule : acm_masked_reg

// [rtl/acm_pkg.sv]
`include "acm_defs.svh"

package acm_pkg;

   // which register an address selects
   typedef enum logic [1:0] {
      ACM_SEL_NONE,
      ACM_SEL_CTRL1,
      ACM_SEL_CTRL0,
      ACM_SEL_GAIN
   } acm_sel_t;

   // address decode, both window bases map to the same registers
   function automatic acm_sel_t acm_decode(input logic [`ACM_ADDR_W-1:0] addr);
      logic [9:0] word;
      acm_sel_t sel;
      word = addr[`ACM_ADDR_W-1:`ACM_WORD_LSB];
      sel = ACM_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         if (word == 10'(`ACM_BASE_BLOCKING + `ACM_IDX_CTRL1) ||
             word == 10'(`ACM_BASE_NONBLOCKING + `ACM_IDX_CTRL1)) begin
            sel = ACM_SEL_CTRL1;
         end else if (word == 10'(`ACM_BASE_BLOCKING + `ACM_IDX_CTRL0) ||
                      word == 10'(`ACM_BASE_NONBLOCKING + `ACM_IDX_CTRL0)) begin
            sel = ACM_SEL_CTRL0;
         end else if (word == 10'(`ACM_BASE_BLOCKING + `ACM_IDX_GAIN) ||
                      word == 10'(`ACM_BASE_NONBLOCKING + `ACM_IDX_GAIN)) begin
            sel = ACM_SEL_GAIN;
         end
      end
      return sel;
   endfunction : acm_decode

endpackage : acm_pkg

// [sim/acm_bus_master.sv]
`timescale 1ns/10ps
`include "acm_defs.svh"

// register bus master standing in for the on-chip software
module acm_bus_master (
   input wire logic clk_i,
   output logic [`ACM_ADDR_W-1:0] awaddr_o,
   output logic awvalid_o,
   input wire logic awready_i,
   output logic [31:0] wdata_o,
   output logic [3:0] wstrb_o,
   output logic wvalid_o,
   input wire logic wready_i,
   input wire logic [1:0] bresp_i,
   input wire logic bvalid_i,
   output logic bready_o,
   output logic [`ACM_ADDR_W-1:0] araddr_o,
   output logic arvalid_o,
   input wire logic arready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   input wire logic rvalid_i,
   output logic rready_o
);
   // idle bus from time zero
   initial begin
      awaddr_o = '0;
      awvalid_o = 1'b0;
      wdata_o = '0;
      wstrb_o = '0;
      wvalid_o = 1'b0;
      bready_o = 1'b0;
      araddr_o = '0;
      arvalid_o = 1'b0;
      rready_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one write: address and data offered together, each held until taken
   task automatic write(input logic [`ACM_ADDR_W-1:0] addr, input logic [31:0] data,
                        input logic [3:0] strb, output logic [1:0] resp);
      logic aw_pend;
      logic w_pend;
      aw_pend = 1'b1;
      w_pend = 1'b1;
      @(posedge clk_i);
      awaddr_o <= addr;
      awvalid_o <= 1'b1;
      wdata_o <= data;
      wstrb_o <= strb;
      wvalid_o <= 1'b1;
      while (aw_pend || w_pend) begin
         @(posedge clk_i);
         // released lines show the inverse, not a stale copy
         if (aw_pend && awready_i) begin
            aw_pend = 1'b0;
            awvalid_o <= 1'b0;
            awaddr_o <= ~addr;
         end
         if (w_pend && wready_i) begin
            w_pend = 1'b0;
            wvalid_o <= 1'b0;
            wdata_o <= ~data;
            wstrb_o <= ~strb;
         end
      end
      // response ready raised late, so the slave has to hold its answer
      repeat (2) @(posedge clk_i);
      bready_o <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (bvalid_i !== 1'b1);
      resp = bresp_i;
      bready_o <= 1'b0;
   endtask : write

   ////////////////////////////////////////////////////////////////////////////////
   // one read: address held until taken, rready held until data seen
   task automatic read(input logic [`ACM_ADDR_W-1:0] addr, output logic [31:0] data,
                       output logic [1:0] resp);
      @(posedge clk_i);
      araddr_o <= addr;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (arready_i !== 1'b1);
      arvalid_o <= 1'b0;
      araddr_o <= ~addr;
      while (rvalid_i !== 1'b1) begin
         @(posedge clk_i);
      end
      data = rdata_i;
      resp = rresp_i;
      rready_o <= 1'b0;
   endtask : read

endmodule : acm_bus_master

// [sim/acq_chain_masked_control_bench.sv]
`timescale 1ns/10ps
`include "acm_defs.svh"

module acq_chain_masked_control_bench;
   // one table row: a write and the control bytes it should leave
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
      logic [1:0] resp;
      logic [7:0] exp1;
      logic [7:0] exp0;
   } acm_row_t;

   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [2:0] auto_code = 3'h0;
   logic [11:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [7:0] c1, c0;
   logic [2:0] gain;
   int miscompares = 0;
   int checks_done = 0;
   acm_row_t rows [9];

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   acm_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .auto_gain_code_i(auto_code),
      .temp_channel_comp_on_o(c1[7]), .volt_channel_comp_on_o(c1[6]),
      .curr_channel_comp_on_o(c1[5]), .lowpass_filter_on_o(c1[4]),
      .ext_temp_chopper_on_o(c1[3]), .int_temp_chopper_on_o(c1[2]),
      .volt_chopper_on_o(c1[1]), .auto_gain_on_o(c1[0]), .input_short_on_o(c0[7]),
      .supply_pin_cap_comp_o(c0[6]), .temp_converter_gain_sel_o(c0[5]),
      .volt_converter_gain_sel_o(c0[4]), .curr_converter_gain_sel_o(c0[3]),
      .temp_input_delay_on_o(c0[2]), .volt_input_delay_on_o(c0[1]),
      .curr_input_delay_on_o(c0[0]), .amplifier_gain_field_o(gain));

   acm_bus_master mst (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
      .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
      .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
      .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
      .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

   ////////////////////////////////////////////////////////////////////////////////
   // compare, count and report
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t ns: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   // bus write with response compare
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic [1:0] r;
      mst.write(a, d, s, r);
      check(32'(r), 32'(er), "write response");
   endtask : wr

   // bus read with data and response compare
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      mst.read(a, d, r);
      check(d, ed, "read data");
      check(32'(r), 32'(er), "read response");
   endtask : rd

   // verdict
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      end_sim();
   end

   // main sequence
   initial begin
      // gate byte in bits 15:8, no write ever touches the converter gain selects
      rows[0] = '{12'h970, 32'h0000_ff00, 4'hf, 2'b00, 8'h00, 8'h38};
      rows[1] = '{12'hd70, 32'hffff_1010, 4'h3, 2'b00, 8'h10, 8'h38};
      rows[2] = '{12'h970, 32'h0000_00ff, 4'hf, 2'b00, 8'h10, 8'h38};
      rows[3] = '{12'h970, 32'h0000_eeee, 4'h3, 2'b00, 8'hfe, 8'h38};
      rows[4] = '{12'h978, 32'h0000_8080, 4'hf, 2'b00, 8'hfe, 8'hb8};
      rows[5] = '{12'hd78, 32'h0000_4747, 4'h3, 2'b00, 8'hfe, 8'hff};
      rows[6] = '{12'h978, 32'h0000_ff00, 4'h1, 2'b10, 8'hfe, 8'hff};
      rows[7] = '{12'h97c, 32'h0000_ff00, 4'hf, 2'b10, 8'hfe, 8'hff};
      rows[8] = '{12'hd78, 32'h0000_8700, 4'hf, 2'b00, 8'hfe, 8'h78};
      repeat (16) @(posedge clk_i);
      check(32'({c1, c0, gain}), 32'({8'he1, 8'h38, 3'h0}), "reset levels");
      resetn_i <= 1'b1;
      rd(12'h970, 32'h0000_00e1, 2'b00);
      rd(12'hd78, 32'h0000_0038, 2'b00);
      $display("test reset done");
      for (int i = 0; i < 9; i++) begin
         wr(rows[i].addr, rows[i].data, rows[i].strb, rows[i].resp);
         check(32'({c1, c0}), 32'({rows[i].exp1, rows[i].exp0}), "control outputs");
         rd(12'h970, 32'(rows[i].exp1), 2'b00);
         rd(12'hd78, 32'(rows[i].exp0), 2'b00);
      end
      rd(12'h97c, 32'h0, 2'b10);
      $display("test table done");
      // manual gain with auto gain off, then auto gain takes over
      @(posedge clk_i);
      auto_code <= 3'h5;
      wr(12'h988, 32'h0000_0007, 4'hf, 2'b00);
      check(32'(gain), 32'h7, "manual gain");
      rd(12'hd88, 32'h0000_0007, 2'b00);
      wr(12'h970, 32'h0000_0101, 4'h3, 2'b00);
      repeat (2) @(posedge clk_i);
      check(32'({c1[0], gain}), 32'({1'b1, 3'h5}), "auto gain");
      wr(12'h988, 32'h0000_0000, 4'hf, 2'b00);
      rd(12'h988, 32'h0000_0005, 2'b00);
      $display("test gain done");
      // second reset in mid-run
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(32'({c1, c0, gain}), 32'({8'he1, 8'h38, 3'h0}), "reset levels");
      resetn_i <= 1'b1;
      rd(12'hd70, 32'h0000_00e1, 2'b00);
      $display("test mid reset done");
      end_sim();
   end

endmodule : acq_chain_masked_control_bench
